// *** verilog/sys_osc_defines.svh ***
// Register map, field positions, reset values and start-up counts
`ifndef SYS_OSC_DEFINES_SVH
`define SYS_OSC_DEFINES_SVH

// ***************************************************
// Register offsets
// ***************************************************
`define ADDR_SYS_CLK_CTRL   8'h00
`define ADDR_FAST_RC_CTRL   8'h01
`define ADDR_SLOW_XTAL_CTRL 8'h02

// ***************************************************
// Field positions
// ***************************************************
`define SCC_DIV_MSB      7
`define SCC_DIV_LSB      5
`define SCC_HS_SRC_BIT   3
`define SCC_LS_SRC_BIT   2
`define SCC_FAST_IDLE    1
`define SCC_SLOW_IDLE    0
`define FRC_FREQ_MSB     3
`define FRC_FREQ_LSB     2
`define FRC_RUN_BIT      0
`define SXC_PIN_BIT      3
`define SXC_SPEEDUP_BIT  2
`define SXC_READY_BIT    1
`define SXC_ENABLE_BIT   0

// ***************************************************
// Reset values and encodings
// ***************************************************
`define SCC_RESET        8'h00
`define FRC_RESET        8'h01
`define SXC_RESET        8'h00
`define DIV_SEL_SLOW     3'h7
`define FRC_FREQ_BAD     2'h3
`define HS_SRC_XTAL      1'h1
`define LS_SRC_XTAL      1'h1

// ***************************************************
// Slow crystal start-up, in crystal periods
// ***************************************************
`define SXT_START_SPEEDUP  16'h0400
`define SXT_START_LOWPOWER 16'h4000

`endif

// *** verilog/sys_osc_pkg.sv ***
// Types shared by the oscillator select design
package sys_osc_pkg;

  // Slow crystal start-up progress
  typedef enum logic [1:0] {
    SXT_OFF,
    SXT_STARTING,
    SXT_READY
  } sxt_state_t;

endpackage : sys_osc_pkg

// *** verilog/clock_ratio_switch.sv ***
// Glitch-free system clock divider and fast/slow source switch
`timescale 1ns/1ps
`include "sys_osc_defines.svh"

module clock_ratio_switch
  import sys_osc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  input  wire logic [2:0] sys_clk_divider_sel,
  input  wire logic       run,
  output logic            sys_clk_en
);

  logic [2:0] active_code;
  logic [5:0] cnt;
  logic [5:0] mask;
  logic       tick_in;
  logic       last;
  logic       fire;

  // ***************************************************
  // Period end detection
  // ***************************************************
  // Code n divides the fast ticks by 2**n; the slow code passes through
  assign mask    = ~(6'h3F << active_code);
  assign tick_in = (active_code == `DIV_SEL_SLOW) ? slow_tick : fast_tick;
  assign last    = (active_code == `DIV_SEL_SLOW) || (cnt == mask);
  assign fire    = run && tick_in && last;

  // New code is taken only at a period boundary, never mid-period
  always_ff @(posedge clk) begin
    if (srst) begin
      active_code <= 3'h0;
      cnt         <= 6'h00;
    end else if (fire) begin
      active_code <= sys_clk_divider_sel; // R16
      cnt         <= 6'h00;
    end else if (run && tick_in) begin
      cnt         <= cnt + 6'h01;         // R4
    end else if (cnt == 6'h00) begin
      active_code <= sys_clk_divider_sel; // R1
    end
  end

  // Stopped while halted, so the core sees no clock
  always_ff @(posedge clk) begin
    if (srst) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= fire;                 // R14
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  AST_SWITCH_AT_EDGE: assert property (@(posedge clk) disable iff (srst) // R16
    (active_code != $past(active_code)) |->
      ($past(fire) || ($past(cnt) == 6'h00)))
    else $error("code changed inside a clock period");

  AST_HALT_STOPS: assert property (@(posedge clk) disable iff (srst) // R14
    !run |=> !sys_clk_en)
    else $error("system clock ran while halted");

  AST_SLOW_PASS: assert property (@(posedge clk) disable iff (srst) // R15
    (run && active_code == `DIV_SEL_SLOW && slow_tick) |=> sys_clk_en)
    else $error("slow tick not passed to system clock");

  AST_DIV_COUNT: assert property (@(posedge clk) disable iff (srst) // R4
    (fire && active_code != `DIV_SEL_SLOW) |->
      (cnt == mask))
    else $error("fast period has wrong tick count");

endmodule : clock_ratio_switch

// *** verilog/system_oscillator_select.sv ***
// Oscillator source selection, slow crystal control and register port
//
// Summary of operation
// R1 - Divider field dynamically picks slow or fast source for the system clock
// R2 - One bit picks internal slow RC or external slow crystal
// R3 - One bit picks external fast crystal or internal fast RC
// R4 - The same divider field sets the delivered system clock rate
// R5 - Exactly one fast and one slow source is always selected
// R6 - Fast RC runs at one of three rates from a two-bit field
// R7 - Software matches the fast RC rate field to the configured rate
// R8 - Writing 1 to the crystal enable starts it; usable after start-up delay
// R9 - Crystal mode bit: 0 low power, 1 speed-up with fast start
// R10 - After start-up, clearing mode keeps the crystal running, lower current
// R11 - Once slow crystal drives the system clock its mode cannot change
// R12 - Crystal works in both modes; low power only starts slower
// R13 - Pin-share bit gives the slow crystal pins to oscillator or I/O; a set crystal enable forces them to the oscillator whatever the bit
// R14 - Halt stops the system clock; independent timer clock keeps running
// R15 - Codes 0 to 6 divide fast clock by 1 to 64; 7 selects slow
// R16 - Source and ratio changes happen without shortened clock phases
`timescale 1ns/1ps
`include "sys_osc_defines.svh"

module system_oscillator_select
  import sys_osc_pkg::*;
#(
  parameter logic [15:0] START_SPEEDUP  = `SXT_START_SPEEDUP,
  parameter logic [15:0] START_LOWPOWER = `SXT_START_LOWPOWER
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       fast_xtal_tick,
  input  wire logic       fast_rc_tick,
  input  wire logic       slow_xtal_tick,
  input  wire logic       slow_rc_tick,
  input  wire logic       halt,
  output logic            sys_clk_en,
  output logic            fast_clk_en,
  output logic            sub_clk_en,
  output logic            timer_clk_en,
  output logic      [1:0] fast_rc_freq_sel,
  output logic            fast_rc_run,
  output logic            fast_xtal_run,
  output logic            fast_xtal_pins_osc,
  output logic            slow_xtal_run,
  output logic            slow_xtal_speedup,
  output logic            slow_xtal_pins_osc
);

  logic [2:0]  sys_clk_divider_sel;
  logic        high_speed_src_sel;
  logic        low_speed_src_sel;
  logic        fast_idle_keep;
  logic        slow_idle_keep;
  logic        fast_rc_keep;
  logic        slow_xtal_enable;
  logic        slow_xtal_pin_sel;
  sxt_state_t  sxt_state;
  logic [15:0] sxt_count;
  logic [15:0] sxt_target;
  logic        sxt_ready;
  logic        sxt_locked;
  logic        wr_scc;
  logic        wr_frc;
  logic        wr_sxc;
  logic        fast_need;
  logic        slow_need;
  logic        fast_src_tick;
  logic        sub_src_tick;
  logic [7:0]  next_rdata;

  // ***************************************************
  // Register decode
  // ***************************************************
  assign wr_scc = reg_wr && (reg_addr == `ADDR_SYS_CLK_CTRL);
  assign wr_frc = reg_wr && (reg_addr == `ADDR_FAST_RC_CTRL);
  assign wr_sxc = reg_wr && (reg_addr == `ADDR_SLOW_XTAL_CTRL);

  // Slow crystal is the live system clock source
  assign sxt_locked = (sys_clk_divider_sel == `DIV_SEL_SLOW) &&
                      (low_speed_src_sel == `LS_SRC_XTAL);
  assign sxt_ready  = (sxt_state == SXT_READY);

  // System clock control: single select bits leave no empty choice
  always_ff @(posedge clk) begin
    if (srst) begin
      sys_clk_divider_sel <= 3'(`SCC_RESET >> `SCC_DIV_LSB);
      high_speed_src_sel  <= 1'(`SCC_RESET >> `SCC_HS_SRC_BIT);
      low_speed_src_sel   <= 1'(`SCC_RESET >> `SCC_LS_SRC_BIT);
      fast_idle_keep      <= 1'(`SCC_RESET >> `SCC_FAST_IDLE);
      slow_idle_keep      <= 1'(`SCC_RESET >> `SCC_SLOW_IDLE);
    end else if (wr_scc) begin
      sys_clk_divider_sel <= reg_wdata[`SCC_DIV_MSB:`SCC_DIV_LSB]; // R1
      high_speed_src_sel  <= reg_wdata[`SCC_HS_SRC_BIT];           // R3
      low_speed_src_sel   <= reg_wdata[`SCC_LS_SRC_BIT];           // R2
      fast_idle_keep      <= reg_wdata[`SCC_FAST_IDLE];
      slow_idle_keep      <= reg_wdata[`SCC_SLOW_IDLE];
    end
  end

  // Fast RC control; the unused rate code is refused so a rate always holds
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_rc_freq_sel <= 2'(`FRC_RESET >> `FRC_FREQ_LSB);
      fast_rc_keep     <= 1'(`FRC_RESET >> `FRC_RUN_BIT);
    end else if (wr_frc) begin
      if (reg_wdata[`FRC_FREQ_MSB:`FRC_FREQ_LSB] != `FRC_FREQ_BAD) begin
        fast_rc_freq_sel <= reg_wdata[`FRC_FREQ_MSB:`FRC_FREQ_LSB]; // R6
      end
      fast_rc_keep     <= reg_wdata[`FRC_RUN_BIT];
    end
  end

  // Slow crystal control; mode is frozen while it clocks the system
  always_ff @(posedge clk) begin
    if (srst) begin
      slow_xtal_enable  <= 1'(`SXC_RESET >> `SXC_ENABLE_BIT);
      slow_xtal_speedup <= 1'(`SXC_RESET >> `SXC_SPEEDUP_BIT);
      slow_xtal_pin_sel <= 1'(`SXC_RESET >> `SXC_PIN_BIT);
    end else if (wr_sxc) begin
      slow_xtal_enable  <= reg_wdata[`SXC_ENABLE_BIT];  // R8
      slow_xtal_pin_sel <= reg_wdata[`SXC_PIN_BIT];     // R13
      if (!sxt_locked) begin
        slow_xtal_speedup <= reg_wdata[`SXC_SPEEDUP_BIT]; // R11
      end
    end
  end

  // ***************************************************
  // Slow crystal start-up
  // ***************************************************
  // Low power mode only lengthens the wait; both modes end ready
  assign sxt_target = slow_xtal_speedup ? START_SPEEDUP   // R9
                                        : START_LOWPOWER; // R12

  // Counts crystal periods; a mode change mid-start just moves the goal
  always_ff @(posedge clk) begin
    if (srst) begin
      sxt_state <= SXT_OFF;
      sxt_count <= 16'h0000;
    end else if (!slow_xtal_enable) begin
      sxt_state <= SXT_OFF;
      sxt_count <= 16'h0000;
    end else begin
      unique case (sxt_state)
        SXT_OFF: begin
          sxt_state <= SXT_STARTING;                // R8
          sxt_count <= 16'h0000;
        end
        SXT_STARTING: begin
          if (slow_xtal_tick) begin
            if (sxt_count >= sxt_target - 16'h0001) begin
              sxt_state <= SXT_READY;               // R8
            end else begin
              sxt_count <= sxt_count + 16'h0001;
            end
          end
        end
        SXT_READY: begin
          sxt_state <= SXT_READY;                   // R10
        end
      endcase
    end
  end

  // ***************************************************
  // Source muxing and clock enables
  // ***************************************************
  // Halt keeps a class alive only where its idle bit asks for it
  assign fast_need     = !halt || fast_idle_keep;
  assign slow_need     = !halt || slow_idle_keep;
  assign fast_src_tick = (high_speed_src_sel == `HS_SRC_XTAL)
                         ? fast_xtal_tick : fast_rc_tick;     // R3
  // An unstarted crystal gives no ticks rather than garbage edges
  assign sub_src_tick  = (low_speed_src_sel == `LS_SRC_XTAL)
                         ? (slow_xtal_tick && sxt_ready)
                         : slow_rc_tick;                       // R2

  // Peripheral and timer clock enables
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_clk_en  <= 1'b0;
      sub_clk_en   <= 1'b0;
      timer_clk_en <= 1'b0;
    end else begin
      fast_clk_en  <= fast_src_tick && fast_need;
      sub_clk_en   <= sub_src_tick && slow_need;
      timer_clk_en <= slow_rc_tick;                // R14
    end
  end

  // Oscillator power and pin ownership; the selected fast one runs except in halt with the fast idle bit clear
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_rc_run        <= 1'b1;
      fast_xtal_run      <= 1'b0;
      fast_xtal_pins_osc <= 1'b0;
      slow_xtal_run      <= 1'b0;
      slow_xtal_pins_osc <= 1'b0;
    end else begin
      fast_rc_run        <= fast_need && ((high_speed_src_sel !=
                            `HS_SRC_XTAL) || fast_rc_keep);      // R5
      fast_xtal_run      <= fast_need &&
                            (high_speed_src_sel == `HS_SRC_XTAL); // R5
      fast_xtal_pins_osc <= (high_speed_src_sel == `HS_SRC_XTAL);
      slow_xtal_run      <= slow_xtal_enable;                     // R10
      slow_xtal_pins_osc <= slow_xtal_pin_sel || slow_xtal_enable; // R13
    end
  end

  // ***************************************************
  // System clock generation
  // ***************************************************
  clock_ratio_switch u_ratio (
    .clk                 (clk),
    .srst                (srst),
    .fast_tick           (fast_src_tick),
    .slow_tick           (sub_src_tick),
    .sys_clk_divider_sel (sys_clk_divider_sel), // R15
    .run                 (!halt),
    .sys_clk_en          (sys_clk_en)
  );

  // ***************************************************
  // Read port
  // ***************************************************
  // Unmapped offsets read zero; data stands one cycle only
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      `ADDR_SYS_CLK_CTRL: begin
        next_rdata[`SCC_DIV_MSB:`SCC_DIV_LSB] = sys_clk_divider_sel;
        next_rdata[`SCC_HS_SRC_BIT]           = high_speed_src_sel;
        next_rdata[`SCC_LS_SRC_BIT]           = low_speed_src_sel;
        next_rdata[`SCC_FAST_IDLE]            = fast_idle_keep;
        next_rdata[`SCC_SLOW_IDLE]            = slow_idle_keep;
      end
      `ADDR_FAST_RC_CTRL: begin
        next_rdata[`FRC_FREQ_MSB:`FRC_FREQ_LSB] = fast_rc_freq_sel;
        next_rdata[`FRC_RUN_BIT]                = fast_rc_keep;
      end
      `ADDR_SLOW_XTAL_CTRL: begin
        next_rdata[`SXC_PIN_BIT]     = slow_xtal_pin_sel;
        next_rdata[`SXC_SPEEDUP_BIT] = slow_xtal_speedup;
        next_rdata[`SXC_READY_BIT]   = sxt_ready;
        next_rdata[`SXC_ENABLE_BIT]  = slow_xtal_enable;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  sequence s_sxt_ready;
    sxt_ready && slow_xtal_enable;
  endsequence

  sequence s_mode_cleared;
    wr_sxc && !reg_wdata[`SXC_SPEEDUP_BIT] && reg_wdata[`SXC_ENABLE_BIT];
  endsequence

  AST_KEEP_RUNNING: assert property (@(posedge clk) disable iff (srst) // R10
    (s_sxt_ready ##0 s_mode_cleared) |=> (sxt_ready && slow_xtal_run))
    else $error("crystal stopped after leaving speed-up");

  AST_MODE_LOCK: assert property (@(posedge clk) disable iff (srst) // R11
    (sxt_locked && wr_sxc) |=> $stable(slow_xtal_speedup))
    else $error("crystal mode changed while clocking system");

  AST_READY_DELAY: assert property (@(posedge clk) disable iff (srst) // R8
    (sxt_state == SXT_STARTING && !sxt_ready) ##1 sxt_ready |->
      ($past(sxt_count) >= $past(sxt_target) - 16'h0001))
    else $error("crystal ready before start-up delay");

  AST_RC_FREQ_LEGAL: assert property (@(posedge clk) disable iff (srst) // R6
    fast_rc_freq_sel != `FRC_FREQ_BAD)
    else $error("fast RC rate code illegal");

  AST_HS_SOURCE: assert property (@(posedge clk) disable iff (srst) // R3
    (fast_need && high_speed_src_sel && fast_xtal_tick) |=> fast_clk_en)
    else $error("fast crystal tick not delivered");

  AST_LS_SOURCE: assert property (@(posedge clk) disable iff (srst) // R2
    (slow_need && !low_speed_src_sel && slow_rc_tick) |=> sub_clk_en)
    else $error("slow RC tick not delivered");

  AST_ONE_FAST_RUNS: assert property (@(posedge clk) disable iff (srst) // R5
    !halt ##1 !halt |-> (fast_rc_run || fast_xtal_run))
    else $error("no fast oscillator running");

  AST_PINS_OWNED: assert property (@(posedge clk) disable iff (srst) // R13
    slow_xtal_run |-> slow_xtal_pins_osc)
    else $error("crystal running without its pins");

  AST_TIMER_FREE: assert property (@(posedge clk) disable iff (srst) // R14
    (halt && slow_rc_tick) |=> timer_clk_en)
    else $error("timer clock stopped in halt");

  AST_READ_DIV: assert property (@(posedge clk) disable iff (srst) // R1
    (reg_rd && reg_addr == `ADDR_SYS_CLK_CTRL) |=>
      (reg_rdata[`SCC_DIV_MSB:`SCC_DIV_LSB] == $past(sys_clk_divider_sel)))
    else $error("divider field read back wrong");

endmodule : system_oscillator_select

// *** sim/system_oscillator_select_tb_top.sv ***
// Self-checking bench for the oscillator select block
`timescale 1ns/1ps
`include "sys_osc_defines.svh"

module system_oscillator_select_tb_top;
  logic       clk;
  logic       srst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] tk;
  logic       halt;
  logic       sys_clk_en;
  logic       fast_clk_en;
  logic       sub_clk_en;
  logic       timer_clk_en;
  logic [1:0] fast_rc_freq_sel;
  logic       fast_rc_run;
  logic       fast_xtal_run;
  logic       fast_xtal_pins_osc;
  logic       slow_xtal_run;
  logic       slow_xtal_speedup;
  logic       slow_xtal_pins_osc;
  int         n_fail;
  int         tests_run;
  int         n_sys;
  int         n_tmr;
  int         n_fast;
  int         n_sub;
  int         s0;
  int         s1;
  int         s2;
  logic [7:0] rv;

  // Start-up counts shortened so a crystal start takes a few ticks
  system_oscillator_select #(
    .START_SPEEDUP  (16'h0004),
    .START_LOWPOWER (16'h0008)
  ) dut (
    .clk                (clk),
    .srst               (srst),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .fast_xtal_tick     (tk[0]),
    .fast_rc_tick       (tk[1]),
    .slow_xtal_tick     (tk[2]),
    .slow_rc_tick       (tk[3]),
    .halt               (halt),
    .sys_clk_en         (sys_clk_en),
    .fast_clk_en        (fast_clk_en),
    .sub_clk_en         (sub_clk_en),
    .timer_clk_en       (timer_clk_en),
    .fast_rc_freq_sel   (fast_rc_freq_sel),
    .fast_rc_run        (fast_rc_run),
    .fast_xtal_run      (fast_xtal_run),
    .fast_xtal_pins_osc (fast_xtal_pins_osc),
    .slow_xtal_run      (slow_xtal_run),
    .slow_xtal_speedup  (slow_xtal_speedup),
    .slow_xtal_pins_osc (slow_xtal_pins_osc)
  );

  // ***************************************************
  // Clock and pulse counters
  // ***************************************************
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Counting in the bench keeps expectations free of design outputs
  always @(posedge clk) begin
    if (sys_clk_en === 1'b1) n_sys <= n_sys + 1;
    if (timer_clk_en === 1'b1) n_tmr <= n_tmr + 1;
    if (fast_clk_en === 1'b1) n_fast <= n_fast + 1;
    if (sub_clk_en === 1'b1) n_sub <= n_sub + 1;
  end

  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // One-cycle tick pulses with a gap, as an oscillator would give
  task automatic pulse(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tk[which] <= 1'b1;
      @(posedge clk);
      tk[which] <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the run needs a few thousand cycles at most
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    n_fail = 0; tests_run = 0; n_sys = 0; n_tmr = 0;
    n_fast = 0;
    n_sub = 0;
    srst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; tk = 4'h0; halt = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Reset values and unmapped offset
    rd(`ADDR_SYS_CLK_CTRL, rv);   chk("scc", rv, 8'h00);
    rd(`ADDR_FAST_RC_CTRL, rv);   chk("frc", rv, 8'h01);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("sxc", rv, 8'h00);
    chk("rc_run", {7'h00, fast_rc_run}, 8'h01);
    wr(8'h3F, 8'hFF);
    rd(8'h3F, rv);                chk("unmapped", rv, 8'h00);
    $display("test reset done");
    // Fast RC rate codes, code 3 refused
    for (int c = 0; c < 3; c++) begin
      wr(`ADDR_FAST_RC_CTRL, 8'(c * 4 + 1));
      rd(`ADDR_FAST_RC_CTRL, rv); chk("frc_rd", rv, 8'(c * 4 + 1));
      chk("rc_freq", {6'h00, fast_rc_freq_sel}, 8'(c));
    end
    wr(`ADDR_FAST_RC_CTRL, 8'hFF);
    rd(`ADDR_FAST_RC_CTRL, rv);   chk("frc_bad", rv, 8'h09);
    $display("test fast rc done");
    // Divider codes 0..6 from the fast RC: 128 ticks give 128/2**n
    for (int n = 0; n < 7; n++) begin
      wr(`ADDR_SYS_CLK_CTRL, 8'(n * 32));
      s0 = n_sys;
      pulse(1, 128);
      chk("div", 8'(n_sys - s0), 8'(128 >> n));
    end
    $display("test divider done");
    // Fast source bit: crystal ticks count only once selected
    wr(`ADDR_SYS_CLK_CTRL, 8'h00);
    s0 = n_sys;
    s1 = n_fast;
    pulse(0, 5);
    chk("xtal_unsel", 8'(n_sys - s0), 8'h00);
    chk("xtal_unsel_fast", 8'(n_fast - s1), 8'h00);
    wr(`ADDR_SYS_CLK_CTRL, 8'h08);
    s0 = n_sys;
    s1 = n_fast;
    pulse(0, 5);
    chk("xtal_sel", 8'(n_sys - s0), 8'h05);
    chk("xtal_sel_fast", 8'(n_fast - s1), 8'h05);
    chk("hx_pins", {7'h00, fast_xtal_pins_osc}, 8'h01);
    chk("hx_run", {7'h00, fast_xtal_run}, 8'h01);
    $display("test fast source done");
    // Halt stops the system clock, timer clock keeps running
    wr(`ADDR_SYS_CLK_CTRL, 8'h00);
    @(posedge clk);
    halt <= 1'b1;
    s0 = n_sys;
    s1 = n_tmr;
    s2 = n_fast;
    pulse(1, 4);
    pulse(3, 4);
    chk("halt_sys", 8'(n_sys - s0), 8'h00);
    chk("halt_fast", 8'(n_fast - s2), 8'h00);
    chk("halt_tmr", 8'(n_tmr - s1), 8'h04);
    halt <= 1'b0;
    $display("test halt done");
    // Code 7 with the slow RC: one system pulse per slow tick
    wr(`ADDR_SYS_CLK_CTRL, 8'hE0);
    s0 = n_sys;
    s1 = n_sub;
    pulse(3, 6);
    chk("slow_rc", 8'(n_sys - s0), 8'h06);
    chk("slow_rc_sub", 8'(n_sub - s1), 8'h06);
    wr(`ADDR_SYS_CLK_CTRL, 8'h00);
    $display("test slow rc done");
    // Slow crystal start in speed-up mode
    wr(`ADDR_SLOW_XTAL_CTRL, 8'h05);
    repeat (3) @(posedge clk);
    pulse(2, 3);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("sx_early", rv, 8'h05);
    pulse(2, 1);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("sx_ready", rv, 8'h07);
    chk("sx_run", {7'h00, slow_xtal_run}, 8'h01);
    chk("sx_spd", {7'h00, slow_xtal_speedup}, 8'h01);
    chk("sx_pins", {7'h00, slow_xtal_pins_osc}, 8'h01);
    // Clearing speed-up after start keeps the crystal ready
    wr(`ADDR_SLOW_XTAL_CTRL, 8'h01);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("sx_lowp", rv, 8'h03);
    $display("test crystal speed-up done");
    // Low-power start needs the longer count
    wr(`ADDR_SLOW_XTAL_CTRL, 8'h00);
    // Pin ownership follows the enable register one cycle later
    repeat (2) @(posedge clk);
    chk("sx_off", {7'h00, slow_xtal_pins_osc}, 8'h00);
    wr(`ADDR_SLOW_XTAL_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    pulse(2, 4);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("lp_early", rv, 8'h01);
    pulse(2, 4);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("lp_ready", rv, 8'h03);
    $display("test crystal low power done");
    // Crystal drives the system clock; its mode is then locked
    wr(`ADDR_SYS_CLK_CTRL, 8'hE4);
    s0 = n_sys;
    pulse(2, 4);
    chk("sx_sys", 8'(n_sys - s0), 8'h04);
    wr(`ADDR_SLOW_XTAL_CTRL, 8'h05);
    rd(`ADDR_SLOW_XTAL_CTRL, rv); chk("lock", rv, 8'h03);
    chk("lock_out", {7'h00, slow_xtal_speedup}, 8'h00);
    $display("test mode lock done");
    end_of_test();
  end
endmodule : system_oscillator_select_tb_top
